/* File: common/dtc_pkg.sv */
// constants, register map and types for the dram termination control block
package dtc_pkg;

    // apb geometry
    localparam int DTC_AW = 8;
    localparam int DTC_DW = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] DTC_CFG_OFS = 8'h00;
    localparam logic [7:0] DTC_LAT_OFS = 8'h04;
    localparam logic [7:0] DTC_STAT_OFS = 8'h08;

    // configuration register fields
    localparam int DTC_CFG_W = 13;
    localparam int DTC_NOM_LSB = 0;
    localparam int DTC_WR_LSB = 3;
    localparam int DTC_PARK_LSB = 6;
    localparam int DTC_PRE2_BIT = 9;
    localparam int DTC_CRC_BIT = 10;
    localparam int DTC_BM_LSB = 11;
    localparam logic [12:0] DTC_CFG_RST = 13'h0000;

    // burst modes
    localparam logic [1:0] DTC_BM_BL8 = 2'h0;
    localparam logic [1:0] DTC_BM_BC4 = 2'h1;
    localparam logic [1:0] DTC_BM_OTF = 2'h2;

    // latency register fields, 6 bits each
    localparam int DTC_LAT_W = 24;
    localparam int DTC_CWL_LSB = 0;
    localparam int DTC_AL_LSB = 6;
    localparam int DTC_PL_LSB = 12;
    localparam int DTC_CL_LSB = 18;
    localparam logic [23:0] DTC_LAT_RST = 24'h2c0009;

    // latency offsets and read window pieces, in clocks
    localparam logic [7:0] DTC_OFS_PRE1 = 8'h02;
    localparam logic [7:0] DTC_OFS_PRE2 = 8'h03;
    localparam logic [3:0] DTC_HALF_BC4 = 4'h2;
    localparam logic [3:0] DTC_HALF_BL8 = 4'h4;
    localparam logic [3:0] DTC_EXT_PRE1 = 4'h2;
    localparam logic [3:0] DTC_EXT_PRE2 = 4'h3;

    // delay line
    localparam int DTC_DLY_DEPTH = 64;
    localparam logic [5:0] DTC_TAP_MIN = 6'h01;
    localparam logic [5:0] DTC_TAP_MAX = 6'h3f;

    // termination states
    typedef enum logic [1:0] {
        DTC_OFF = 2'b00,
        DTC_NOM = 2'b01,
        DTC_WR = 2'b10,
        DTC_PARK = 2'b11
    } dtc_term_t;

endpackage

/* File: hdl/dtc_delay_line.sv */
// shift register delay line with a run-time tap
`timescale 1ns/1ps
module dtc_delay_line (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic din,
    input wire logic [5:0] tap,
    output logic dout
);
    import dtc_pkg::*;

    logic [DTC_DLY_DEPTH-1:0] stage;
    logic [5:0] idx;

    // one flop per stage; stage k holds din delayed k+1 clocks
    genvar g;
    generate
        for (g = 0; g < DTC_DLY_DEPTH; g++) begin : g_stage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage[g] <= 1'b0;
                end else if (g == 0) begin
                    stage[g] <= din;
                end else begin
                    stage[g] <= stage[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    // tap of n gives din delayed n clocks; tap below one is clamped
    assign idx = (tap < DTC_TAP_MIN) ? 6'h00 : tap - DTC_TAP_MIN;
    assign dout = stage[idx];

endmodule // dtc_delay_line

/* File: hdl/dtc_term_ctrl.sv */
// termination selection and timing with its apb register file
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module dtc_term_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dtc_pkg::DTC_AW-1:0] paddr,
    input wire logic [dtc_pkg::DTC_DW-1:0] pwdata,
    output logic pready,
    output logic [dtc_pkg::DTC_DW-1:0] prdata,
    output logic pslverr,
    // dram side, synchronous to pclk
    input wire logic odt_pin,
    input wire logic cmd_read,
    input wire logic wr_window,
    input wire logic dll_locked,
    input wire logic self_refresh,
    // termination control
    output dtc_pkg::dtc_term_t term_state,
    output logic [2:0] term_value,
    output logic pin_rx_enable,
    output logic read_blank
);
    import dtc_pkg::*;

    // register storage
    logic [DTC_CFG_W-1:0] cfg;
    logic [DTC_LAT_W-1:0] lat;

    // apb decode
    logic setup_phase;
    logic access_done;
    logic hit_cfg;
    logic hit_lat;
    logic hit_stat;
    logic hit_any;
    logic wr_cfg;
    logic wr_lat;
    logic [DTC_DW-1:0] rd_mux;
    logic [DTC_DW-1:0] stat_word;

    // configuration fields
    logic [2:0] nom_val;
    logic [2:0] wr_val;
    logic [2:0] park_val;
    logic pre2;
    logic crc_en;
    logic [1:0] burst_mode;
    logic [5:0] cwl;
    logic [5:0] al;
    logic [5:0] pl;
    logic [5:0] cl;

    // derived latencies
    logic [7:0] lat_ofs;
    logic [7:0] pin_sum;
    logic [7:0] rd_sum;
    logic [5:0] pin_lat;
    logic [5:0] rd_off_lat;
    logic [3:0] half_burst;
    logic [3:0] pre_ext;
    logic [3:0] rd_dur;

    // pin and read timing
    logic nom_enabled;
    logic pin_gated;
    logic pin_q;
    logic pin_delayed;
    logic nom_active;
    logic rd_tap;
    logic [3:0] rd_cnt;
    logic [3:0] next_rd_cnt;
    logic next_read_blank;

    // selection
    dtc_term_t next_term_state;
    logic [2:0] next_term_value;

    // field extraction
    assign nom_val = cfg[DTC_NOM_LSB +: 3];
    assign wr_val = cfg[DTC_WR_LSB +: 3];
    assign park_val = cfg[DTC_PARK_LSB +: 3];
    assign pre2 = cfg[DTC_PRE2_BIT];
    assign crc_en = cfg[DTC_CRC_BIT];
    assign burst_mode = cfg[DTC_BM_LSB +: 2];
    assign cwl = lat[DTC_CWL_LSB +: 6];
    assign al = lat[DTC_AL_LSB +: 6];
    assign pl = lat[DTC_PL_LSB +: 6];
    assign cl = lat[DTC_CL_LSB +: 6];

    // fit a latency into the delay line; too short a latency still costs one clock
    function automatic logic [5:0] dtc_fit(input logic [7:0] sum, input logic [7:0] ofs);
        logic [7:0] diff;
        diff = sum - ofs;
        if (sum <= ofs) begin
            dtc_fit = DTC_TAP_MIN;
        end else if (diff > {2'b00, DTC_TAP_MAX}) begin
            dtc_fit = DTC_TAP_MAX;
        end else begin
            dtc_fit = diff[5:0];
        end
    endfunction

    // preamble picks the offset subtracted from every latency
    assign lat_ofs = pre2 ? DTC_OFS_PRE2 : DTC_OFS_PRE1;
    assign pin_sum = {2'b00, cwl} + {2'b00, al} + {2'b00, pl};
    assign rd_sum = {2'b00, cl} + {2'b00, al} + {2'b00, pl};
    // turn-on and turn-off share one latency
    assign pin_lat = dtc_fit(pin_sum, lat_ofs);
    assign rd_off_lat = dtc_fit(rd_sum, lat_ofs);

    // read blanking length; on-the-fly bursts are timed as the longer burst
    assign half_burst = (burst_mode == DTC_BM_BC4) ? DTC_HALF_BC4 : DTC_HALF_BL8;
    assign pre_ext = pre2 ? DTC_EXT_PRE2 : DTC_EXT_PRE1;
    assign rd_dur = half_burst + pre_ext + {3'b000, crc_en};

    // apb decode; all registers answer in the first access cycle
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign hit_cfg = (paddr == DTC_CFG_OFS);
    assign hit_lat = (paddr == DTC_LAT_OFS);
    assign hit_stat = (paddr == DTC_STAT_OFS);
    assign hit_any = hit_cfg || hit_lat || hit_stat;
    assign wr_cfg = access_done && pwrite && hit_cfg;
    assign wr_lat = access_done && pwrite && hit_lat;

    // status shows live selection and timing state
    assign stat_word = {23'h000000, dll_locked, pin_q, read_blank, pin_rx_enable,
                        term_value, term_state};

    // read mux; unmapped addresses read zero
    assign rd_mux = hit_cfg ? {19'h00000, cfg} :
                    hit_lat ? {8'h00, lat} :
                    hit_stat ? stat_word :
                    32'h00000000;

    // pready rises for the access cycle only, so back to back transfers work
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            prdata <= setup_phase && !pwrite ? rd_mux : 32'h00000000;
            pslverr <= setup_phase && !hit_any;
        end
    end

    // register writes take effect at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= DTC_CFG_RST;
            lat <= DTC_LAT_RST;
        end else begin
            if (wr_cfg) begin
                cfg <= pwdata[DTC_CFG_W-1:0];
            end
            if (wr_lat) begin
                lat <= pwdata[DTC_LAT_W-1:0];
            end
        end
    end

    // pin is only heeded with nominal enabled and outside self refresh
    assign nom_enabled = (nom_val != 3'h0);
    assign pin_gated = odt_pin && nom_enabled && !self_refresh;

    // registered pin; also feeds the dll-off path without latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_gated;
        end
    end

    // pin delayed by the common turn-on and turn-off latency
    dtc_delay_line u_pin_dly (
        .pclk(pclk),
        .presetn(presetn),
        .din(pin_gated),
        .tap(pin_lat),
        .dout(pin_delayed)
    );

    // sync timing while locked; unlocked, the registered pin is used without latency
    assign nom_active = nom_enabled && (dll_locked ? pin_delayed : pin_q);

    // read commands delayed to the termination-off point
    dtc_delay_line u_rd_dly (
        .pclk(pclk),
        .presetn(presetn),
        .din(cmd_read),
        .tap(rd_off_lat),
        .dout(rd_tap)
    );

    // a later read reloads the window, so overlapping reads merge cleanly
    assign next_rd_cnt = rd_tap ? rd_dur : (rd_cnt != 4'h0) ? rd_cnt - 4'h1 : 4'h0;
    assign next_read_blank = (next_rd_cnt != 4'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_cnt <= 4'h0;
            read_blank <= 1'b0;
        end else begin
            rd_cnt <= next_rd_cnt;
            read_blank <= next_read_blank;
        end
    end

    // priority selection each clock from settings, pin and windows
    always_comb begin
        next_term_state = DTC_OFF;
        next_term_value = 3'h0;
        if (self_refresh || next_read_blank) begin
            next_term_state = DTC_OFF;
            next_term_value = 3'h0;
        end else if (wr_window && (wr_val != 3'h0)) begin
            next_term_state = DTC_WR;
            next_term_value = wr_val;
        end else if (nom_active) begin
            next_term_state = DTC_NOM;
            next_term_value = nom_val;
        end else if (park_val != 3'h0) begin
            next_term_state = DTC_PARK;
            next_term_value = park_val;
        end else begin
            // all fields zero leaves termination disabled
            next_term_state = DTC_OFF;
            next_term_value = 3'h0;
        end
    end

    // state moves only on rising edges; outputs straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_state <= DTC_OFF;
            term_value <= 3'h0;
            pin_rx_enable <= 1'b0;
        end else begin
            term_state <= next_term_state;
            term_value <= next_term_value;
            pin_rx_enable <= nom_enabled;
        end
    end

endmodule // dtc_term_ctrl

/* File: testbench/dtc_term_ctrl_props.sv */
// port-level assertions for the termination control block
`timescale 1ns/1ps
module dtc_term_ctrl_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [dtc_pkg::DTC_AW-1:0] paddr,
    input wire logic pready,
    input wire logic [dtc_pkg::DTC_DW-1:0] prdata,
    input wire logic pslverr,
    // dram side
    input wire logic cmd_read,
    input wire logic self_refresh,
    // termination
    input wire dtc_pkg::dtc_term_t term_state,
    input wire logic [2:0] term_value,
    input wire logic pin_rx_enable,
    input wire logic read_blank
);
    import dtc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // apb answers exactly one cycle after setup
    a_apb_answer: assert property (psel && !penable |=> pready) else $error("pready late");
    a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
        else $error("pslverr wrong");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_sr_off: assert property (self_refresh |=> term_state == DTC_OFF) else $error("on in sr");
    a_off_zero: assert property (term_state == DTC_OFF |-> term_value == 3'h0) else $error("value");
    a_blank_hiz: assert property (read_blank |-> term_state == DTC_OFF) else $error("on in read");
    // a read must open its window within the largest latency
    a_read_start: assert property (cmd_read && !self_refresh |-> ##[1:63] read_blank)
        else $error("read window missing");
    a_blank_len: assert property ($rose(read_blank) |-> read_blank[*4]) else $error("short");
    a_rx_gate: assert property ((!pin_rx_enable)[*3] |-> term_state != DTC_NOM)
        else $error("nominal with receiver off");
    c_read: cover property ($rose(read_blank));
    c_write: cover property (term_state == DTC_WR);
    c_nom: cover property (term_state == DTC_NOM);
    c_err: cover property (pready && pslverr);
endmodule // dtc_term_ctrl_props

bind dtc_term_ctrl dtc_term_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmd_read(cmd_read), .self_refresh(self_refresh), .term_state(term_state),
    .term_value(term_value), .pin_rx_enable(pin_rx_enable), .read_blank(read_blank));

/* File: testbench/dtc_ctrl_model.sv */
// memory controller model driving the termination pin and command strobes
`timescale 1ns/1ps
module dtc_ctrl_model (
    // clock
    input wire logic pclk,
    // dram side
    output logic odt_pin,
    output logic cmd_read,
    output logic wr_window
);
    initial begin
        odt_pin = 1'b0;
        cmd_read = 1'b0;
        wr_window = 1'b0;
    end
    // pin held high n clocks; callers pass at least the burst hold time
    task automatic odt_pulse(input int n);
        @(posedge pclk) odt_pin <= 1'b1;
        repeat (n) @(posedge pclk);
        odt_pin <= 1'b0;
    endtask
    // registered read is a single-cycle strobe
    task automatic read_cmd();
        @(posedge pclk) cmd_read <= 1'b1;
        @(posedge pclk) cmd_read <= 1'b0;
    endtask
    task automatic write_period(input int n);
        @(posedge pclk) wr_window <= 1'b1;
        repeat (n) @(posedge pclk);
        wr_window <= 1'b0;
    endtask
endmodule // dtc_ctrl_model

/* File: testbench/dtc_term_ctrl_tb.sv */
// self-checking bench for termination selection and timing
`timescale 1ns/1ps
module dtc_term_ctrl_tb;
    import dtc_pkg::*;
    logic pclk = 1'b0;
    logic presetn;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, odt_pin, cmd_read, wr_window, pin_rx_enable, read_blank;
    logic dll_locked, self_refresh;
    logic [2:0] term_value;
    dtc_term_t term_state;
    int n_mismatch = 0, n_compared = 0;
    // read timing table: cfg word, off latency, window length
    logic [31:0] cf[4] = '{32'h0d1, 32'h8d1, 32'h6d1, 32'h10d1};
    int rl[4] = '{9, 9, 8, 9};
    int dl[4] = '{6, 4, 8, 6};
    always #5 pclk = ~pclk;
    dtc_term_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .odt_pin(odt_pin), .cmd_read(cmd_read), .wr_window(wr_window), .dll_locked(dll_locked),
        .self_refresh(self_refresh), .term_state(term_state), .term_value(term_value),
        .pin_rx_enable(pin_rx_enable), .read_blank(read_blank));
    dtc_ctrl_model m (.pclk(pclk), .odt_pin(odt_pin), .cmd_read(cmd_read), .wr_window(wr_window));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ts(input dtc_term_t st, input logic [2:0] v);
        check("term_state", term_state, st);
        check("term_value", term_value, v);
    endtask
    // one apb transfer; waits on pready, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
    initial begin
        // idle bus, reset asserted, dll locked, awake
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        dll_locked = 1'b1;
        self_refresh = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DTC_CFG_OFS, 32'h0);
        check("cfg reset", rd, 32'h0);
        apb(1'b0, DTC_LAT_OFS, 32'h0);
        check("lat reset", rd, 32'h2c0009);
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped err", err, 32'h1);
        step(2);
        ts(DTC_OFF, 3'h0);
        // nominal 1, write 2, parked 3, bl8, 1-clock preamble
        apb(1'b1, DTC_CFG_OFS, 32'h0d1);
        apb(1'b0, DTC_CFG_OFS, 32'h0);
        check("cfg", rd, 32'h0d1);
        step(3);
        ts(DTC_PARK, 3'h3);
        check("rx", pin_rx_enable, 32'h1);
        // status: dll locked, receiver on, parked value 3
        apb(1'b0, DTC_STAT_OFS, 32'h0);
        check("stat", rd, 32'h12f);
        // pin latency cwl-2 = 7 each way
        fork m.odt_pulse(6); join_none
        @(posedge pclk);
        step(7);
        ts(DTC_PARK, 3'h3);
        step(1);
        ts(DTC_NOM, 3'h1);
        step(5);
        ts(DTC_NOM, 3'h1);
        step(1);
        ts(DTC_PARK, 3'h3);
        // write period overrides parked; nominal follows when the delayed pin arrives after it
        fork m.odt_pulse(6); m.write_period(3); join_none
        @(posedge pclk);
        step(2);
        ts(DTC_WR, 3'h2);
        step(6);
        ts(DTC_NOM, 3'h1);
        step(10);
        foreach (cf[i]) begin
            apb(1'b1, DTC_CFG_OFS, cf[i]);
            step(4);
            fork m.read_cmd(); join_none
            @(posedge pclk);
            step(rl[i]);
            ts(DTC_PARK, 3'h3);
            step(1);
            ts(DTC_OFF, 3'h0);
            check("blank", read_blank, 32'h1);
            step(dl[i] - 1);
            ts(DTC_OFF, 3'h0);
            step(1);
            ts(DTC_PARK, 3'h3);
        end
        // posted latency: cwl 9, al 2, pl 1 gives 10 clocks each way
        apb(1'b1, DTC_LAT_OFS, 32'h1089);
        apb(1'b0, DTC_LAT_OFS, 32'h0);
        check("lat", rd, 32'h1089);
        step(2);
        fork m.odt_pulse(6); join_none
        @(posedge pclk);
        step(10);
        ts(DTC_PARK, 3'h3);
        step(1);
        ts(DTC_NOM, 3'h1);
        step(6);
        ts(DTC_PARK, 3'h3);
        // nominal field zero: pin ignored, receiver off
        apb(1'b1, DTC_CFG_OFS, 32'h0d0);
        step(3);
        check("rx off", pin_rx_enable, 32'h0);
        fork m.odt_pulse(6); join_none
        step(10);
        ts(DTC_PARK, 3'h3);
        // self refresh shuts termination off; receiver enable stays on
        apb(1'b1, DTC_CFG_OFS, 32'h0d1);
        @(posedge pclk);
        self_refresh <= 1'b1;
        step(2);
        ts(DTC_OFF, 3'h0);
        fork m.odt_pulse(6); join_none
        step(10);
        ts(DTC_OFF, 3'h0);
        @(posedge pclk);
        self_refresh <= 1'b0;
        dll_locked <= 1'b0;
        step(8);
        // dll off: no latency beyond the pin register
        fork m.odt_pulse(6); join_none
        @(posedge pclk);
        step(1);
        ts(DTC_PARK, 3'h3);
        step(1);
        ts(DTC_NOM, 3'h1);
        step(5);
        ts(DTC_NOM, 3'h1);
        step(1);
        ts(DTC_PARK, 3'h3);
        repeat (4) @(posedge pclk);
        dll_locked <= 1'b1;
        apb(1'b1, DTC_CFG_OFS, 32'h0);
        step(3);
        ts(DTC_OFF, 3'h0);
        final_report();
    end
endmodule // dtc_term_ctrl_tb
